// File: logic/pdt_pkg.sv
/*
 * Constants, register map and carrier types of the programmable down timer.
 * Assumes a 50 MHz system clock and a CPU that reaches the block through
 * 4-bit I/O data memory words at 12-bit addresses.
 */
// Contract
// (RULE1) 8-bit down-counter; zero sets event flag.
// (RULE2) Flag sets on zero whatever the mask.
// (RULE3) Interrupt request only when mask bit is 1.
// (RULE4) Reload zero gives a modulo-256 count.
// (RULE5) 3-bit field selects external or prescaled clock.
// (RULE6) Filtered input sampled at 256 Hz rate; the filter here samples at 512 Hz, two samples per 256 Hz period.
// (RULE7) Writing 1 to restart bit reloads counter.
// (RULE8) Run bit counts when 1, holds when 0.
// (RULE9) Software loads reload, restarts, then sets run.
// (RULE10) Software stops briefly to read both nibbles.
// (RULE11) Counter value readable as two nibbles.
// (RULE12) Reload value held in two read/write nibbles.
// (RULE13) Flag and mask in D0, upper bits zero.
// (RULE14) Clock output enable in D3 of select word.
// (RULE15) Reading the flag word clears it.
// (RULE16) Each selected clock edge decrements by one.
// (RULE17) Restart and zero both load reload value.
// (RULE18) Clock edges while stopped leave counter unchanged.

package pdt_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register addresses of the I/O data memory words.
    localparam logic [11:0] ADDR_EVENT_FLAG = 12'hf02;
    localparam logic [11:0] ADDR_EVENT_MASK = 12'hf12;
    localparam logic [11:0] ADDR_COUNT_LOW = 12'hf24;
    localparam logic [11:0] ADDR_COUNT_HIGH = 12'hf25;
    localparam logic [11:0] ADDR_RELOAD_LOW = 12'hf26;
    localparam logic [11:0] ADDR_RELOAD_HIGH = 12'hf27;
    localparam logic [11:0] ADDR_RUN_CONTROL = 12'hf78;
    localparam logic [11:0] ADDR_CLOCK_SELECT = 12'hf79;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions inside the 4-bit words.
    localparam int FLAG_BIT = 0;
    localparam int ENABLE_BIT = 0;
    localparam int RUN_BIT = 0;
    localparam int RESTART_BIT = 1;
    localparam int OUT_EN_BIT = 3;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values.
    localparam logic [7:0] RELOAD_RESET = 8'h00;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [2:0] SEL_RESET = 3'h0;
    localparam logic [3:0] READ_ZERO = 4'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Count clock selection codes.
    localparam logic [2:0] SEL_EXT_FILTERED = 3'h0;
    localparam logic [2:0] SEL_EXT_DIRECT = 3'h1;
    localparam logic [2:0] SEL_FASTEST = 3'h7;
    localparam logic [2:0] SEL_256HZ = 3'h2;
    localparam logic [2:0] SEL_512HZ = 3'h3;

    ////////////////////////////////////////////////////////////////////////////
    // Timing: the fastest prescaled rate is made from the system clock.
    localparam int CLK_HZ = 50000000;
    localparam int BASE_HZ = 8192;
    localparam int BASE_DIV = CLK_HZ / BASE_HZ;
    localparam int PRESCALE_BITS = 5;

    ////////////////////////////////////////////////////////////////////////////
    // One CPU access to the I/O data memory.
    typedef struct packed {
        logic [11:0] addr;
        logic [3:0] wdata;
        logic wr;
        logic rd;
    } pdt_cpu_req_t;

endpackage

// File: logic/pdt_timer.sv
/*
 * Programmable 8-bit down timer with reload, selectable count clock,
 * zero event flag with mask, and a count clock output.
 * Assumes the CPU presents one access per cycle on cpu_req and the external
 * count input is asynchronous to mclk.
 */
`timescale 1ns/1ns
`default_nettype none

module pdt_timer #(
    parameter int BASE_DIV = pdt_pkg::BASE_DIV
) (
    // System clock and synchronous active low reset.
    input wire logic mclk,
    input wire logic nrst,
    // CPU access to the I/O data memory words.
    input wire pdt_pkg::pdt_cpu_req_t cpu_req,
    output logic [3:0] cpu_rdata,
    // External count pin.
    input wire logic external_count_input,
    // Interrupt request and count clock output.
    output logic timer_irq,
    output logic count_clock_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Prescaler tap decode: a code of 2 to 7 ticks when the low bits of the
    // prescale counter are all ones, fewer bits for faster rates.
    function automatic logic tap_hit(input logic [2:0] code,
                                     input logic [4:0] pre);
        logic [4:0] mask;
        mask = 5'h1f >> (3'(code) - 3'h2);
        tap_hit = ((pre & mask) == mask);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Registers.
    logic [12:0] base_cnt; // Divider to the fastest prescaled rate.
    logic [4:0] pre_cnt; // Binary prescale chain below the fastest rate.
    logic [7:0] count_value; // The down-counter.
    logic [7:0] reload_value; // Reload nibbles.
    logic count_run; // Run bit.
    logic [2:0] count_clock_sel; // Count clock selection field.
    logic count_clock_out_en; // Clock output enable.
    logic zero_event_flag; // Sticky zero event flag.
    logic zero_event_enable; // Interrupt mask bit.
    logic [2:0] pin_sync; // Three-stage synchroniser of the pin.
    logic pin_level; // Pin level once stages two and three agree.
    logic pin_sampled; // Pin level accepted by the noise filter.
    logic pin_first; // Earlier of two successive filter samples.
    logic direct_prev; // Previous direct level for edge detection.
    logic filtered_prev; // Previous sampled level for edge detection.

    ////////////////////////////////////////////////////////////////////////////
    // Count clock sources, decode of the CPU access and next-state values.
    wire logic base_tick;
    wire logic filter_tick;
    wire logic prescaled_tick;
    wire logic direct_edge;
    wire logic filtered_edge;
    wire logic count_tick;
    wire logic wr_mask;
    wire logic wr_rel_lo;
    wire logic wr_rel_hi;
    wire logic wr_run;
    wire logic wr_sel;
    wire logic rd_flag;
    wire logic restart;
    wire logic [7:0] dec_value;
    wire logic hit_zero;
    logic [7:0] next_count;
    logic [3:0] next_rdata;

    // Address matches, one per word that a write can touch.
    assign wr_mask = cpu_req.wr && (cpu_req.addr == pdt_pkg::ADDR_EVENT_MASK);
    assign wr_rel_lo = cpu_req.wr && (cpu_req.addr == pdt_pkg::ADDR_RELOAD_LOW);
    assign wr_rel_hi = cpu_req.wr && (cpu_req.addr == pdt_pkg::ADDR_RELOAD_HIGH);
    assign wr_run = cpu_req.wr && (cpu_req.addr == pdt_pkg::ADDR_RUN_CONTROL);
    assign wr_sel = cpu_req.wr && (cpu_req.addr == pdt_pkg::ADDR_CLOCK_SELECT);
    // A read of the flag word clears the flag after it has been captured.
    assign rd_flag = cpu_req.rd && (cpu_req.addr == pdt_pkg::ADDR_EVENT_FLAG); // RULE15
    // Only a 1 in the restart bit acts; it is never stored.
    assign restart = wr_run && cpu_req.wdata[pdt_pkg::RESTART_BIT]; // RULE7

    ////////////////////////////////////////////////////////////////////////////
    // Count clock sources.
    assign base_tick = (base_cnt == 13'(BASE_DIV - 1));
    // The noise filter takes two samples in each 256 Hz period.
    assign filter_tick = base_tick && tap_hit(pdt_pkg::SEL_512HZ, pre_cnt); // RULE6
    // Codes 2 to 7 pick 256 Hz up to 8192 Hz, doubling per step.
    assign prescaled_tick = base_tick && tap_hit(count_clock_sel, pre_cnt); // RULE5
    // The external pin counts on its falling edge, as a key press.
    assign direct_edge = direct_prev && !pin_level;
    assign filtered_edge = filtered_prev && !pin_sampled;
    // Selection between the external and the internal count clocks.
    assign count_tick = (count_clock_sel == pdt_pkg::SEL_EXT_FILTERED) ? filtered_edge
                      : (count_clock_sel == pdt_pkg::SEL_EXT_DIRECT) ? direct_edge
                      : prescaled_tick; // RULE5

    ////////////////////////////////////////////////////////////////////////////
    // Down-count arithmetic. The step that would land on zero reports the
    // event and reloads, so a reload of zero wraps through all 256 values.
    assign dec_value = count_value - 8'h01; // RULE16
    assign hit_zero = (dec_value == 8'h00); // RULE1 RULE4

    // Next counter value: restart first, then a running tick.
    always_comb
    begin
        next_count = count_value;
        if (restart)
        begin
            next_count = reload_value; // RULE17 RULE7
        end
        else if (count_run && count_tick)
        begin
            // A zero step reloads so counting goes on without a pause.
            next_count = hit_zero ? reload_value : dec_value; // RULE17 RULE4
        end
        // A tick with the run bit clear leaves the value alone.
    end // RULE18 RULE8

    // Read data selection; words not listed read as zero.
    always_comb
    begin
        next_rdata = pdt_pkg::READ_ZERO;
        if (cpu_req.addr == pdt_pkg::ADDR_EVENT_FLAG)
        begin
            next_rdata[pdt_pkg::FLAG_BIT] = zero_event_flag; // RULE13
        end
        else if (cpu_req.addr == pdt_pkg::ADDR_EVENT_MASK)
        begin
            next_rdata[pdt_pkg::ENABLE_BIT] = zero_event_enable; // RULE13
        end
        else if (cpu_req.addr == pdt_pkg::ADDR_COUNT_LOW)
        begin
            next_rdata = count_value[3:0]; // RULE11
        end
        else if (cpu_req.addr == pdt_pkg::ADDR_COUNT_HIGH)
        begin
            next_rdata = count_value[7:4]; // RULE11
        end
        else if (cpu_req.addr == pdt_pkg::ADDR_RELOAD_LOW)
        begin
            next_rdata = reload_value[3:0]; // RULE12
        end
        else if (cpu_req.addr == pdt_pkg::ADDR_RELOAD_HIGH)
        begin
            next_rdata = reload_value[7:4]; // RULE12
        end
        else if (cpu_req.addr == pdt_pkg::ADDR_RUN_CONTROL)
        begin
            // The restart bit is write only and reads zero.
            next_rdata[pdt_pkg::RUN_BIT] = count_run; // RULE8
        end
        else if (cpu_req.addr == pdt_pkg::ADDR_CLOCK_SELECT)
        begin
            next_rdata = {count_clock_out_en, count_clock_sel}; // RULE14
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Divider from the system clock to the fastest prescaled rate.
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            base_cnt <= 13'h0000;
        end
        else
        begin
            base_cnt <= base_tick ? 13'h0000 : base_cnt + 13'h0001;
        end
    end

    // Prescale chain advanced once per fastest tick.
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            pre_cnt <= 5'h00;
        end
        else if (base_tick)
        begin
            pre_cnt <= pre_cnt + 5'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchroniser; stage one feeds only stage two.
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            pin_sync <= 3'h0;
        end
        else
        begin
            pin_sync <= {pin_sync[1:0], external_count_input};
        end
    end

    // The pin level changes only when stages two and three agree. The filter
    // takes a level only when two samples in a row agree, so chatter shorter
    // than the gap between samples never reaches the counter.
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            pin_level <= 1'b0;
            direct_prev <= 1'b0;
            pin_first <= 1'b0;
            pin_sampled <= 1'b0;
            filtered_prev <= 1'b0;
        end
        else
        begin
            if (pin_sync[1] == pin_sync[2])
            begin
                pin_level <= pin_sync[2];
            end
            direct_prev <= pin_level;
            if (filter_tick)
            begin
                pin_first <= pin_level;
                if (pin_first == pin_level)
                begin
                    pin_sampled <= pin_level; // RULE6
                end
            end
            filtered_prev <= pin_sampled;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // The down-counter itself.
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            count_value <= pdt_pkg::COUNT_RESET;
        end
        else
        begin
            count_value <= next_count; // RULE16
        end
    end

    // Software written control words.
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            reload_value <= pdt_pkg::RELOAD_RESET;
            count_run <= 1'b0;
            count_clock_sel <= pdt_pkg::SEL_RESET;
            count_clock_out_en <= 1'b0;
            zero_event_enable <= 1'b0;
        end
        else
        begin
            if (wr_rel_lo)
            begin
                reload_value[3:0] <= cpu_req.wdata; // RULE12
            end
            if (wr_rel_hi)
            begin
                reload_value[7:4] <= cpu_req.wdata; // RULE12
            end
            if (wr_run)
            begin
                count_run <= cpu_req.wdata[pdt_pkg::RUN_BIT]; // RULE8
            end
            if (wr_sel)
            begin
                count_clock_sel <= cpu_req.wdata[2:0]; // RULE5
                count_clock_out_en <= cpu_req.wdata[pdt_pkg::OUT_EN_BIT]; // RULE14
            end
            if (wr_mask)
            begin
                zero_event_enable <= cpu_req.wdata[pdt_pkg::ENABLE_BIT]; // RULE13
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sticky zero event flag; a new event wins over a clearing read.
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            zero_event_flag <= 1'b0;
        end
        else if (count_run && count_tick && hit_zero && !restart)
        begin
            // The mask plays no part in setting the flag.
            zero_event_flag <= 1'b1; // RULE1 RULE2
        end
        else if (rd_flag)
        begin
            zero_event_flag <= 1'b0; // RULE15
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registered read data, interrupt request and clock output.
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            cpu_rdata <= pdt_pkg::READ_ZERO;
            timer_irq <= 1'b0;
            count_clock_out <= 1'b0;
        end
        else
        begin
            if (cpu_req.rd)
            begin
                cpu_rdata <= next_rdata;
            end
            // The request follows the flag only while the mask bit is 1.
            timer_irq <= zero_event_flag && zero_event_enable; // RULE3
            // The output toggles on each selected count clock edge.
            if (!count_clock_out_en)
            begin
                count_clock_out <= 1'b0; // RULE14
            end
            else if (count_tick)
            begin
                count_clock_out <= !count_clock_out; // RULE14
            end
        end
    end

endmodule // pdt_timer

`default_nettype wire

// File: testbench/pdt_key_model.sv
/*
 * Key switch on the count pin: idle high, low while pressed.
 * Assumes press requests are one-cycle pulses from the bench.
 */
`timescale 1ns/1ns
`default_nettype none

module pdt_key_model (
    // Clock and press request.
    input wire logic mclk,
    input wire logic press,
    input wire logic [15:0] hold,
    // Count pin.
    output logic pin
);
    logic [15:0] left = 16'h0000; // Cycles of the press still to run.

    // A press pulls the pin low for hold cycles; release lets the pull-up win.
    always @(posedge mclk)
    begin
        if (press)
            left <= hold;
        else if (left != 16'h0000)
            left <= left - 16'h0001;
    end
    assign pin = (left == 16'h0000);
endmodule // pdt_key_model

`default_nettype wire

// File: testbench/pdt_timer_props.sv
/*
 * Checker of the programmable down timer, watching the top module's ports.
 * Assumes one CPU access per cycle and shadows of the written registers.
 */
`timescale 1ns/1ns
`default_nettype none

module pdt_timer_props (
    // Clock and reset.
    input wire logic mclk,
    input wire logic nrst,
    // CPU access.
    input wire pdt_pkg::pdt_cpu_req_t cpu_req,
    input wire logic [3:0] cpu_rdata,
    // Pin, request and clock output.
    input wire logic external_count_input,
    input wire logic timer_irq,
    input wire logic count_clock_out
);
    logic mask_q; // Shadow of the mask bit.
    logic run_q; // Shadow of the run bit.
    logic [3:0] sel_q; // Shadow of the clock select word.
    wire logic [11:0] a = cpu_req.addr;
    wire logic mapped = a inside {12'hf02, 12'hf12, 12'hf24, 12'hf25, 12'hf26, 12'hf27,
        12'hf78, 12'hf79};

    ////////////////////////////////////////////////////////////////////////////
    // Shadows follow the CPU writes so reads can be judged.
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            mask_q <= 1'b0;
            run_q <= 1'b0;
            sel_q <= 4'h0;
        end
        else if (cpu_req.wr)
        begin
            if (a == 12'hf12) mask_q <= cpu_req.wdata[0];
            if (a == 12'hf78) run_q <= cpu_req.wdata[0];
            if (a == 12'hf79) sel_q <= cpu_req.wdata;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    irq_masked_a: assert property (!mask_q && !$past(mask_q) |-> !timer_irq)
        else $error("request raised while masked");
    mask_read_a: assert property ($past(cpu_req.rd && a == 12'hf12) |->
        cpu_rdata == {3'b000, $past(mask_q)}) else $error("mask word read wrong");
    flag_upper_a: assert property ($past(cpu_req.rd && a == 12'hf02) |->
        cpu_rdata[3:1] == 3'b000) else $error("flag word upper bits set");
    run_read_a: assert property ($past(cpu_req.rd && a == 12'hf78) |->
        cpu_rdata == {3'b000, $past(run_q)}) else $error("run word read wrong");
    sel_read_a: assert property ($past(cpu_req.rd && a == 12'hf79) |->
        cpu_rdata == $past(sel_q)) else $error("select word read wrong");
    unmapped_zero_a: assert property ($past(cpu_req.rd && !mapped) |-> cpu_rdata == 4'h0)
        else $error("unmapped read not zero");
    rdata_hold_a: assert property (!$past(cpu_req.rd) |-> $stable(cpu_rdata))
        else $error("read data moved without a read");
    clkout_off_a: assert property (!sel_q[3] && !$past(sel_q[3]) |-> !count_clock_out)
        else $error("clock output active while disabled");
endmodule // pdt_timer_props

`default_nettype wire

// File: testbench/pdt_timer_tb.sv
/*
 * Self-checking bench of the programmable down timer.
 * Assumes a short prescaler (BASE_DIV of 4) and inputs driven on falling edges.
 */
`timescale 1ns/1ns
`default_nettype none

module pdt_timer_tb;
    localparam int DIV = 4; // Shortened prescaler.
    logic mclk;
    logic nrst;
    pdt_pkg::pdt_cpu_req_t req;
    logic [3:0] rdata;
    logic pin;
    logic irq;
    logic cko;
    logic press;
    logic [15:0] hold;
    int failures;
    int n_checks;
    int cyc;
    logic [3:0] got;

    pdt_timer #(.BASE_DIV(DIV)) dut (.mclk(mclk), .nrst(nrst), .cpu_req(req),
        .cpu_rdata(rdata), .external_count_input(pin), .timer_irq(irq),
        .count_clock_out(cko));
    pdt_key_model key (.mclk(mclk), .press(press), .hold(hold), .pin(pin));

    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    always @(posedge mclk) cyc <= cyc + 1;

    ////////////////////////////////////////////////////////////////////////////
    // Shared tasks for checks, bus cycles and waits.
    task automatic wrap_up();
        if (failures == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e)
        begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [11:0] ad, input logic [3:0] d);
        @(negedge mclk);
        req.addr = ad;
        req.wdata = d;
        req.wr = 1'b1;
        @(negedge mclk);
        req.wr = 1'b0;
    endtask
    task automatic rd(input logic [11:0] ad, output logic [3:0] v);
        @(negedge mclk);
        req.addr = ad;
        req.rd = 1'b1;
        @(negedge mclk);
        req.rd = 1'b0;
        v = rdata;
    endtask
    task automatic wait_irq(output int t);
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 3000)
        begin
            @(negedge mclk);
            n++;
        end
        if (n >= 3000)
        begin
            failures++;
            wrap_up();
        end
        t = cyc;
    endtask
    task automatic start(input logic [3:0] sel, input logic [7:0] rl, input logic [3:0] m);
        wr(12'hf79, sel);
        wr(12'hf26, rl[3:0]);
        wr(12'hf27, rl[7:4]);
        wr(12'hf12, m);
        wr(12'hf78, 4'h2);
        wr(12'hf78, 4'h1);
    endtask
    task automatic key_press(input logic [15:0] h);
        @(negedge mclk);
        hold = h;
        press = 1'b1;
        @(negedge mclk);
        press = 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios.
    task automatic s_regs();
        logic [11:0] t[8] = '{12'hf02, 12'hf12, 12'hf24, 12'hf25, 12'hf26, 12'hf27,
            12'hf78, 12'hf79};
        foreach (t[i])
        begin
            rd(t[i], got);
            chk(got, 4'h0);
        end
        wr(12'hf79, 4'hf);
        rd(12'hf79, got);
        chk(got, 4'hf);
        wr(12'hf12, 4'hf);
        rd(12'hf12, got);
        chk(got, 4'h1);
        rd(12'hf00, got);
        chk(got, 4'h0);
    endtask
    task automatic s_reload();
        wr(12'hf79, 4'h7);
        wr(12'hf26, 4'ha);
        wr(12'hf27, 4'h5);
        wr(12'hf78, 4'h2);
        wr(12'hf24, 4'h0);
        repeat (40) @(negedge mclk);
        rd(12'hf24, got);
        chk(got, 4'ha);
        rd(12'hf25, got);
        chk(got, 4'h5);
        rd(12'hf26, got);
        chk(got, 4'ha);
        rd(12'hf78, got);
        chk(got, 4'h0);
    endtask
    task automatic s_masked();
        start(4'h7, 8'h01, 4'h0);
        repeat (20) @(negedge mclk);
        chk(irq, 1'b0);
        wr(12'hf78, 4'h0);
        rd(12'hf02, got);
        chk(got, 4'h1);
    endtask
    task automatic s_period(input logic [2:0] sel, input logic [7:0] rl, input int e);
        int t0;
        int t1;
        start({1'b1, sel}, rl, 4'h1);
        wait_irq(t0);
        rd(12'hf02, got);
        chk(got, 4'h1);
        @(negedge mclk);
        chk(irq, 1'b0);
        wait_irq(t1);
        chk(t1 - t0, e);
        got[0] = cko;
        repeat (DIV << (7 - sel)) @(negedge mclk);
        chk(cko, !got[0]);
        wr(12'hf78, 4'h0);
        rd(12'hf25, got);
        if (rl != 8'h00) chk(got, 4'h0);
        rd(12'hf02, got);
    endtask
    task automatic s_key();
        int t0;
        start(4'h1, 8'h02, 4'h1);
        key_press(16'h000a);
        repeat (30) @(negedge mclk);
        chk(irq, 1'b0);
        key_press(16'h000a);
        repeat (30) @(negedge mclk);
        chk(irq, 1'b1);
        wr(12'hf78, 4'h0);
        rd(12'hf02, got);
        key_press(16'h000a);
        repeat (30) @(negedge mclk);
        rd(12'hf24, got);
        chk(got, 4'h2);
        start(4'h0, 8'h01, 4'h1);
        key_press(16'h0014);
        repeat (300) @(negedge mclk);
        chk(irq, 1'b0);
        key_press(16'h012c);
        wait_irq(t0);
    endtask

    initial
    begin
        req = '0;
        nrst = 1'b0;
        press = 1'b0;
        hold = 16'h0000;
        failures = 0;
        n_checks = 0;
        cyc = 0;
        repeat (16) @(negedge mclk);
        nrst = 1'b1;
        s_regs();
        s_reload();
        s_masked();
        for (int c = 2; c < 8; c++) s_period(c[2:0], 8'h02, (2 * DIV) << (7 - c));
        s_period(3'h7, 8'h00, 256 * DIV);
        s_key();
        wrap_up();
    end
endmodule // pdt_timer_tb

bind pdt_timer pdt_timer_props props (.mclk(mclk), .nrst(nrst), .cpu_req(cpu_req),
    .cpu_rdata(cpu_rdata), .external_count_input(external_count_input),
    .timer_irq(timer_irq), .count_clock_out(count_clock_out));

`default_nettype wire
